// >>> bscs_pkg.sv
package bscs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] CLOCK_CONFIG_TWO_OFS = 16'h1c1f;
    localparam logic [15:0] BOOT_SELECT_OFS = 16'h1c34;

    // Field positions
    localparam int BOOT_CODE_LSB = 5;
    localparam int BOOT_FREQ_LSB = 9;
    localparam int CLK_PIN_BIT = 2;
    localparam int SYSCLK_BIT = 0;

    // Reset values
    localparam logic SYSCLK_RST = 1'b0;
    localparam logic [3:0] BOOT_CODE_RST = 4'h0;
    localparam logic [1:0] BOOT_FREQ_RST = 2'h0;

    // Frequency straps settle by the tenth edge after release
    localparam logic [3:0] FREQ_CAPTURE_CNT = 4'h9;

    // ----------------------------------------------------------------
    // Boot codes
    // ----------------------------------------------------------------
    localparam logic [3:0] CODE_NOR = 4'h0;
    localparam logic [3:0] CODE_NAND = 4'h1;
    localparam logic [3:0] CODE_UART_LO = 4'h2;
    localparam logic [3:0] CODE_UART_MID = 4'h3;
    localparam logic [3:0] CODE_UART_HI = 4'h4;
    localparam logic [3:0] CODE_SPI_SLOW = 4'h5;
    localparam logic [3:0] CODE_SPI_FAST = 4'h6;
    localparam logic [3:0] CODE_POLL_SERIAL = 4'h7;
    localparam logic [3:0] CODE_I2C = 4'h8;
    localparam logic [3:0] CODE_CARD0 = 4'h9;
    localparam logic [3:0] CODE_CARD1 = 4'ha;
    localparam logic [3:0] CODE_POLL_CARDS = 4'hb;
    localparam logic [3:0] CODE_HOST = 4'hc;
    localparam logic [3:0] CODE_MCSER_SLOW = 4'hd;
    localparam logic [3:0] CODE_MCSER_FAST = 4'he;
    localparam logic [3:0] CODE_USB = 4'hf;

    // Boot source chosen by the loader
    typedef enum logic [3:0] {
        SRC_NOR = 4'h0,
        SRC_NAND = 4'h1,
        SRC_UART = 4'h2,
        SRC_SPI = 4'h3,
        SRC_POLL = 4'h4,
        SRC_I2C = 4'h5,
        SRC_CARD = 4'h6,
        SRC_HOST = 4'h7,
        SRC_MCSER = 4'h8,
        SRC_USB = 4'h9
    } bscs_src_e;

    // Rate index: UART 0..2 = 9600/57600/115200 baud,
    // SPI 0..1 = below 1/10 MHz, serial port 0..1 = 10/40 MHz.
    // Poll order: NOR, NAND, SPI, I2C, card 0, then slot, UART/USB.
    typedef struct packed {
        bscs_src_e src;
        logic synth_x3;     // Clock generator at input x 3
        logic [1:0] rate;
        logic addr24;       // 24-bit addressing available
        logic addr16;       // 16-bit addressing available
        logic card_unit;    // Card controller 1 (or card in poll slot)
    } bscs_cfg_s;

    // Register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bscs_req_s;

endpackage

// >>> bscs_regs.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ns

module bscs_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire bscs_pkg::bscs_req_s bus_req,
    output logic [15:0] rdata,
    // Strap and select pins
    input wire logic [3:0] ext_addr_strap_pins,
    input wire logic [3:0] gpio_strap_pins,
    input wire logic [1:0] freq_strap_pins,
    input wire logic strap_from_gpio,
    input wire logic clock_source_pin_state,
    input wire logic card_command_line,
    // Decoded boot setup
    output bscs_pkg::bscs_cfg_s boot_cfg,
    output logic system_clock_source_bit,
    output logic card_probe_hold
);

    // ----------------------------------------------------------------
    // Boot code decode
    // ----------------------------------------------------------------
    // Used only for the registered boot setup
    function automatic bscs_pkg::bscs_cfg_s decode_code(input logic [3:0] code);
        bscs_pkg::bscs_cfg_s c;
        c = '0;
        c.src = bscs_pkg::SRC_NOR;
        case (code)
            bscs_pkg::CODE_NOR: begin
                c.addr16 = 1'b1;
            end
            bscs_pkg::CODE_NAND: begin
                c.src = bscs_pkg::SRC_NAND;
            end
            bscs_pkg::CODE_UART_LO, bscs_pkg::CODE_UART_MID,
            bscs_pkg::CODE_UART_HI: begin
                c.src = bscs_pkg::SRC_UART;
                c.synth_x3 = 1'b1;
                c.rate = 2'(code - bscs_pkg::CODE_UART_LO);
            end
            bscs_pkg::CODE_SPI_SLOW, bscs_pkg::CODE_SPI_FAST: begin
                c.src = bscs_pkg::SRC_SPI;
                c.synth_x3 = 1'b1;
                c.addr16 = 1'b1;
                c.addr24 = 1'b1;
                c.rate = 2'(code - bscs_pkg::CODE_SPI_SLOW);
            end
            bscs_pkg::CODE_POLL_SERIAL: begin
                c.src = bscs_pkg::SRC_POLL;
            end
            bscs_pkg::CODE_I2C: begin
                c.src = bscs_pkg::SRC_I2C;
                c.addr16 = 1'b1;
            end
            bscs_pkg::CODE_CARD0, bscs_pkg::CODE_CARD1: begin
                c.src = bscs_pkg::SRC_CARD;
                c.card_unit = code[1];
            end
            bscs_pkg::CODE_POLL_CARDS: begin
                c.src = bscs_pkg::SRC_POLL;
                c.card_unit = 1'b1;
            end
            bscs_pkg::CODE_HOST: begin
                c.src = bscs_pkg::SRC_HOST;
                c.synth_x3 = 1'b1;
                c.addr16 = 1'b1;
            end
            bscs_pkg::CODE_MCSER_SLOW, bscs_pkg::CODE_MCSER_FAST: begin
                c.src = bscs_pkg::SRC_MCSER;
                c.addr24 = 1'b1;
                c.rate = 2'(code - bscs_pkg::CODE_MCSER_SLOW);
            end
            default: begin
                c.src = bscs_pkg::SRC_USB;
                c.synth_x3 = 1'b1;
            end
        endcase
        return c;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic released_reg, released_next;
    logic [3:0] edge_cnt_reg, edge_cnt_next;
    logic [3:0] boot_code_reg, boot_code_next;
    logic [1:0] boot_freq_reg, boot_freq_next;
    bscs_pkg::bscs_cfg_s cfg_reg, cfg_next;
    logic sysclk_reg, sysclk_next;
    logic [15:0] rdata_reg, rdata_next;
    logic hold_reg, hold_next;
    logic [3:0] strap_mux;
    logic hit_ccr, hit_boot;

    assign strap_mux = strap_from_gpio ? gpio_strap_pins : ext_addr_strap_pins;
    assign hit_ccr = bus_req.addr == bscs_pkg::CLOCK_CONFIG_TWO_OFS;
    assign hit_boot = bus_req.addr == bscs_pkg::BOOT_SELECT_OFS;

    // ----------------------------------------------------------------
    // Strap capture after reset release
    // ----------------------------------------------------------------
    // Reset is asynchronous, so the pins are sampled by a clocked edge
    // after release rather than by the reset itself.
    always_comb begin
        released_next = 1'b1;
        edge_cnt_next = edge_cnt_reg;
        boot_code_next = boot_code_reg;
        boot_freq_next = boot_freq_reg;
        if (!released_reg) begin
            boot_code_next = strap_mux;
        end
        if (edge_cnt_reg != 4'hf) begin
            edge_cnt_next = edge_cnt_reg + 4'h1;
        end
        if (edge_cnt_reg == bscs_pkg::FREQ_CAPTURE_CNT) begin
            boot_freq_next = freq_strap_pins;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            released_reg <= 1'b0;
            edge_cnt_reg <= 4'h0;
            boot_code_reg <= bscs_pkg::BOOT_CODE_RST;
            boot_freq_reg <= bscs_pkg::BOOT_FREQ_RST;
        end else begin
            released_reg <= released_next;
            edge_cnt_reg <= edge_cnt_next;
            boot_code_reg <= boot_code_next;
            boot_freq_reg <= boot_freq_next;
        end
    end

    // ----------------------------------------------------------------
    // Boot setup and card probing
    // ----------------------------------------------------------------
    // Decode one cycle behind the code so the output is a flop
    always_comb begin
        cfg_next = decode_code(boot_code_reg);
        // Probe holds while a card is in play and its command line is low
        hold_next = (cfg_reg.src == bscs_pkg::SRC_CARD ||
                     cfg_reg.src == bscs_pkg::SRC_POLL) && !card_command_line;
    end

    // Registered so boot_cfg never shows a decode glitch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= '0;
            hold_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            hold_reg <= hold_next;
        end
    end

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    // Only the clock source bit is stored; reserved write bits are dropped
    always_comb begin
        sysclk_next = sysclk_reg;
        rdata_next = 16'h0000;
        if (bus_req.wr && hit_ccr) begin
            sysclk_next = bus_req.wdata[bscs_pkg::SYSCLK_BIT];
        end
        if (bus_req.rd && hit_ccr) begin
            rdata_next[bscs_pkg::CLK_PIN_BIT] = clock_source_pin_state;
            rdata_next[bscs_pkg::SYSCLK_BIT] = sysclk_reg;
        end else if (bus_req.rd && hit_boot) begin
            rdata_next[bscs_pkg::BOOT_CODE_LSB +: 4] = boot_code_reg;
            rdata_next[bscs_pkg::BOOT_FREQ_LSB +: 2] = boot_freq_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sysclk_reg <= bscs_pkg::SYSCLK_RST;
            rdata_reg <= 16'h0000;
        end else begin
            sysclk_reg <= sysclk_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs straight from flops
    assign rdata = rdata_reg;
    assign boot_cfg = cfg_reg;
    assign system_clock_source_bit = sysclk_reg;
    assign card_probe_hold = hold_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_code_capture: assert property (
        !released_reg |=> boot_code_reg == $past(strap_mux))
        else $error("boot code not taken on first edge");

    a_code_frozen: assert property (
        released_reg |=> $stable(boot_code_reg))
        else $error("boot code moved after capture");

    a_freq_tenth: assert property (
        edge_cnt_reg == 4'h9 |=> boot_freq_reg == $past(freq_strap_pins))
        else $error("frequency straps not taken on tenth edge");

    a_freq_stable: assert property (
        edge_cnt_reg > 4'h9 |=> $stable(boot_freq_reg))
        else $error("frequency straps moved after capture");

    a_bypass_codes: assert property (
        released_reg && boot_code_reg inside {4'h0, 4'h1, 4'h8, 4'h9, 4'ha}
        |=> !cfg_reg.synth_x3)
        else $error("bypass boot code left generator at times three");

    a_times3_codes: assert property (
        released_reg && boot_code_reg inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hc, 4'hf}
        |=> cfg_reg.synth_x3)
        else $error("boot code did not select times three");

    a_uart_rate: assert property (
        released_reg && boot_code_reg == 4'h4
        |=> cfg_reg.src == bscs_pkg::SRC_UART && cfg_reg.rate == 2'h2)
        else $error("fast UART code decoded wrong");

    a_card_unit: assert property (
        released_reg && boot_code_reg == 4'ha
        |=> cfg_reg.src == bscs_pkg::SRC_CARD && cfg_reg.card_unit)
        else $error("card controller 1 code decoded wrong");

    a_card_hold: assert property (
        cfg_reg.src == bscs_pkg::SRC_CARD && !card_command_line |=> card_probe_hold)
        else $error("probe not held with command line low");

    a_pin_read: assert property (
        bus_req.rd && hit_ccr |=> rdata[2] == $past(clock_source_pin_state)
        && rdata[15:3] == 13'h0000 && rdata[1] == 1'b0)
        else $error("clock config read wrong");

    a_sysclk_write: assert property (
        bus_req.wr && hit_ccr |=> system_clock_source_bit == $past(bus_req.wdata[0])
        ##1 (system_clock_source_bit == $past(system_clock_source_bit, 1) || $past(bus_req.wr)))
        else $error("clock source bit did not follow write");

    a_boot_ro: assert property (
        bus_req.rd && hit_boot |=> rdata[15:11] == 5'h00 && rdata[4:0] == 5'h00
        && rdata[8:5] == $past(boot_code_reg) && rdata[10:9] == $past(boot_freq_reg))
        else $error("boot register read wrong");

    a_boot_no_write: assert property (
        released_reg && bus_req.wr && hit_boot |=> $stable(boot_code_reg))
        else $error("write reached boot register");

    a_sysclk_hold: assert property (
        !(bus_req.wr && hit_ccr) |=> $stable(system_clock_source_bit))
        else $error("clock source bit moved without a write");

    a_card_release: assert property (
        card_command_line |=> !card_probe_hold)
        else $error("probe held with command line high");

    a_spi_codes: assert property (
        released_reg && boot_code_reg inside {4'h5, 4'h6}
        |=> cfg_reg.src == bscs_pkg::SRC_SPI && cfg_reg.rate == {1'b0, $past(boot_code_reg[1])})
        else $error("SPI code decoded wrong");

    a_poll_codes: assert property (
        released_reg && boot_code_reg inside {4'h7, 4'hb}
        |=> cfg_reg.src == bscs_pkg::SRC_POLL && cfg_reg.card_unit == $past(boot_code_reg[3]))
        else $error("polling code decoded wrong");

    a_i2c_code: assert property (
        released_reg && boot_code_reg == 4'h8
        |=> cfg_reg.src == bscs_pkg::SRC_I2C && cfg_reg.addr16)
        else $error("I2C code decoded wrong");

    a_host_usb: assert property (
        released_reg && boot_code_reg inside {4'hc, 4'hf}
        |=> cfg_reg.src == ($past(boot_code_reg[0]) ? bscs_pkg::SRC_USB : bscs_pkg::SRC_HOST))
        else $error("host or USB code decoded wrong");

    a_serial_fast: assert property (
        released_reg && boot_code_reg == 4'he
        |=> cfg_reg.src == bscs_pkg::SRC_MCSER && cfg_reg.addr24 && cfg_reg.rate == 2'h1)
        else $error("fast serial port code decoded wrong");

    c_ccr_write: cover property (bus_req.wr && hit_ccr && bus_req.wdata[0]);
    c_card_probe: cover property (card_probe_hold);
    c_boot_read: cover property (released_reg && bus_req.rd && hit_boot);
    c_usb_boot: cover property (cfg_reg.src == bscs_pkg::SRC_USB);
    c_freq_capture: cover property (edge_cnt_reg == bscs_pkg::FREQ_CAPTURE_CNT);

endmodule

// >>> bscs_regs_bench.sv
`timescale 1ns/1ns

module bscs_regs_bench;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk;
    logic resetn;
    bscs_pkg::bscs_req_s bus_req;
    logic [15:0] rdata;
    logic [3:0] ext_addr_strap_pins;
    logic [3:0] gpio_strap_pins;
    logic [1:0] freq_strap_pins;
    logic strap_from_gpio;
    logic clock_source_pin_state;
    logic card_command_line;
    bscs_pkg::bscs_cfg_s boot_cfg;
    logic system_clock_source_bit;
    logic card_probe_hold;
    int n_fail;
    int tests_run;

    // Device under test
    bscs_regs i_dut (
        .clk(clk),
        .resetn(resetn),
        .bus_req(bus_req),
        .rdata(rdata),
        .ext_addr_strap_pins(ext_addr_strap_pins),
        .gpio_strap_pins(gpio_strap_pins),
        .freq_strap_pins(freq_strap_pins),
        .strap_from_gpio(strap_from_gpio),
        .clock_source_pin_state(clock_source_pin_state),
        .card_command_line(card_command_line),
        .boot_cfg(boot_cfg),
        .system_clock_source_bit(system_clock_source_bit),
        .card_probe_hold(card_probe_hold)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Counts: compares=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Bus tasks are entered just after a rising edge and leave on one
    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
        bus_req <= {a, d, 2'b10};
        @(posedge clk);
        bus_req <= '0;
        @(posedge clk);
    endtask

    task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
        bus_req <= {a, 16'h0000, 2'b01};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    // Unused strap set carries the inverse, so a wrong mux shows up
    task automatic do_reset(input logic [3:0] c, input logic g, input logic [1:0] f);
        resetn <= 1'b0;
        strap_from_gpio <= g;
        gpio_strap_pins <= g ? c : ~c;
        ext_addr_strap_pins <= g ? ~c : c;
        freq_strap_pins <= f;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask

    // Expected decode and mask of the fields that the code fixes
    function automatic logic [19:0] exp_cfg(input logic [3:0] c);
        case (c)
            4'h0: return {bscs_pkg::SRC_NOR, 6'h02, 10'h3e2};
            4'h1: return {bscs_pkg::SRC_NAND, 6'h00, 10'h3e0};
            4'h2: return {bscs_pkg::SRC_UART, 6'h20, 10'h3f8};
            4'h3: return {bscs_pkg::SRC_UART, 6'h28, 10'h3f8};
            4'h4: return {bscs_pkg::SRC_UART, 6'h30, 10'h3f8};
            4'h5: return {bscs_pkg::SRC_SPI, 6'h20, 10'h3f8};
            4'h6: return {bscs_pkg::SRC_SPI, 6'h28, 10'h3f8};
            4'h7: return {bscs_pkg::SRC_POLL, 6'h00, 10'h3c1};
            4'h8: return {bscs_pkg::SRC_I2C, 6'h02, 10'h3e2};
            4'h9: return {bscs_pkg::SRC_CARD, 6'h00, 10'h3e1};
            4'ha: return {bscs_pkg::SRC_CARD, 6'h01, 10'h3e1};
            4'hb: return {bscs_pkg::SRC_POLL, 6'h01, 10'h3c1};
            4'hc: return {bscs_pkg::SRC_HOST, 6'h20, 10'h3e0};
            4'hd: return {bscs_pkg::SRC_MCSER, 6'h04, 10'h3dc};
            4'he: return {bscs_pkg::SRC_MCSER, 6'h0c, 10'h3dc};
            default: return {bscs_pkg::SRC_USB, 6'h20, 10'h3e0};
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Straps flip after capture; freq straps carry their true value only
    // after the first edge and flip again once the capture window closes
    task automatic boot_case(input logic [3:0] c);
        logic [19:0] e;
        logic [15:0] d;
        e = exp_cfg(c);
        do_reset(c, c[0], ~c[2:1]);
        ext_addr_strap_pins <= ~ext_addr_strap_pins;
        gpio_strap_pins <= ~gpio_strap_pins;
        freq_strap_pins <= c[2:1];
        @(posedge clk);
        @(negedge clk);
        chk({6'h00, boot_cfg} & {6'h00, e[9:0]}, {6'h00, e[19:10] & e[9:0]});
        repeat (12) @(posedge clk);
        freq_strap_pins <= ~freq_strap_pins;
        bus_wr(bscs_pkg::BOOT_SELECT_OFS, 16'hffff);
        bus_rd(bscs_pkg::BOOT_SELECT_OFS, d);
        chk(d, {5'h00, c[2:1], c, 5'h00});
    endtask

    task automatic t_decode;
        for (int c = 0; c < 5; c++) boot_case(4'(c));
        for (int c = 5; c < 8; c++) boot_case(4'(c));
        for (int c = 8; c < 12; c++) boot_case(4'(c));
        for (int c = 12; c < 16; c++) boot_case(4'(c));
        $display("Test decode finished");
    endtask

    // Reserved write bits 3 and 1 kept zero, the rest set to probe masking
    task automatic t_clock_cfg;
        logic [15:0] d;
        do_reset(4'h0, 1'b0, 2'h0);
        for (int p = 0; p < 2; p++) begin
            clock_source_pin_state <= p[0];
            bus_rd(bscs_pkg::CLOCK_CONFIG_TWO_OFS, d);
            chk(d, {13'h0000, p[0], 2'b00});
            bus_wr(bscs_pkg::CLOCK_CONFIG_TWO_OFS, 16'hfff5);
            chk({15'h0000, system_clock_source_bit}, 16'h0001);
            bus_rd(bscs_pkg::CLOCK_CONFIG_TWO_OFS, d);
            chk(d, {13'h0000, p[0], 2'b01});
            bus_wr(bscs_pkg::CLOCK_CONFIG_TWO_OFS, 16'h0000);
            chk({15'h0000, system_clock_source_bit}, 16'h0000);
        end
        bus_rd(16'h1c20, d);
        chk(d, 16'h0000);
        $display("Test clock config finished");
    endtask

    // Card, poll and plain NOR modes, command line low then high
    task automatic t_card_hold;
        logic [3:0] codes [3];
        codes = '{4'h9, 4'h7, 4'h0};
        for (int i = 0; i < 3; i++) begin
            do_reset(codes[i], 1'b1, 2'h0);
            for (int l = 0; l < 2; l++) begin
                card_command_line <= l[0];
                repeat (3) @(posedge clk);
                chk({15'h0000, card_probe_hold}, {15'h0000, codes[i] != 4'h0 && !l[0]});
            end
        end
        $display("Test card hold finished");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        bus_req = '0;
        ext_addr_strap_pins = 4'h0;
        gpio_strap_pins = 4'h0;
        freq_strap_pins = 2'h0;
        strap_from_gpio = 1'b0;
        clock_source_pin_state = 1'b0;
        card_command_line = 1'b1;
        n_fail = 0;
        tests_run = 0;
        @(posedge clk);
        t_decode;
        t_clock_cfg;
        t_card_hold;
        wrap_up;
    end

    // A hang is cut short and counted as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up;
    end

endmodule
